// >>> pkg/minsel_alu_pkg.sv
// Package with register map, field layout, constants and carrier types of the DSP ALU block
package minsel_alu_pkg;

    // Register byte offsets on the APB bus
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SRC_A_LO = 8'h04;
    localparam logic [7:0] OFS_SRC_A_HI = 8'h08;
    localparam logic [7:0] OFS_SRC_B_LO = 8'h0C;
    localparam logic [7:0] OFS_SRC_B_HI = 8'h10;
    localparam logic [7:0] OFS_WORD = 8'h14;
    localparam logic [7:0] OFS_IMM = 8'h18;
    localparam logic [7:0] OFS_EXT_LO = 8'h1C;
    localparam logic [7:0] OFS_EXT_HI = 8'h20;
    localparam logic [7:0] OFS_DIF_LO = 8'h24;
    localparam logic [7:0] OFS_DIF_HI = 8'h28;
    localparam logic [7:0] OFS_SHORT = 8'h2C;
    localparam logic [7:0] OFS_DEC_A = 8'h30;
    localparam logic [7:0] OFS_DEC_B = 8'h34;
    localparam logic [7:0] OFS_STATUS = 8'h38;

    // Control word field positions
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_SAT_BIT = 4;
    localparam int CTRL_WIDE_BIT = 5;
    localparam int CTRL_LEGACY_BIT = 6;
    localparam int CTRL_DEC_SEL_BIT = 7;
    localparam int CTRL_TC_SEL_BIT = 8;
    localparam int CTRL_SRC_ACC_BIT = 9;
    localparam int CTRL_GO_BIT = 31;

    // Status word field positions
    localparam int STAT_OVF_BIT = 0;
    localparam int STAT_CARRY_BIT = 1;
    localparam int STAT_TC1_BIT = 2;
    localparam int STAT_TC2_BIT = 3;
    localparam int STAT_BUSY_BIT = 4;

    // Arithmetic constants
    localparam logic [39:0] SAT_POS_WIDE = 40'h7F_FFFF_FFFF;
    localparam logic [39:0] SAT_NEG_WIDE = 40'h80_0000_0000;
    localparam logic [39:0] SAT_POS_NARROW = 40'h00_7FFF_FFFF;
    localparam logic [39:0] SAT_NEG_NARROW = 40'hFF_8000_0000;
    localparam logic [5:0] ACC_TOP_BIT = 6'h27;
    localparam logic [15:0] EXP_BIAS = 16'h0008;
    localparam logic [15:0] NORM_ZERO_VALUE = 16'h8000;

    // Operations
    typedef enum logic [3:0] {
        OP_MINSEL,
        OP_CMP_MEM,
        OP_TGL_ACC,
        OP_TGL_SHORT,
        OP_NOT_ACC,
        OP_NOT_SHORT,
        OP_TGL_MEM,
        OP_EXP,
        OP_NORM
    } op_type;

    // Control fields of one operation
    typedef struct packed {
        logic [3:0] op;
        logic sat;
        logic wide;
        logic legacy;
        logic dec_sel;
        logic tc_sel;
        logic src_acc;
    } ctrl_type;

    // Whole state of the block
    typedef struct packed {
        ctrl_type ctrl;
        logic go;
        logic [39:0] src_a;
        logic [39:0] src_b;
        logic [15:0] word;
        logic [15:0] imm;
        logic [39:0] res_ext;
        logic [39:0] res_dif;
        logic [15:0] res_short;
        logic [15:0] dec_a;
        logic [15:0] dec_b;
        logic ovf;
        logic carry;
        logic tc1;
        logic tc2;
        logic [31:0] rdata;
    } state_type;

    localparam state_type STATE_RESET = '0;

endpackage : minsel_alu_pkg

// >>> logic/lead_norm_unit.sv
// Leading-bit counter with exponent and mantissa alignment for a 40-bit accumulator
`timescale 1ns/1ps
module lead_norm_unit (
    input wire logic [39:0] acc,
    output logic is_zero,
    output logic [15:0] exp_val,
    output logic [15:0] nexp_val,
    output logic [39:0] mant
);

    logic [5:0] lead;

    // Shifts toward the top needed to align as a signed 40-bit value
    function automatic logic [5:0] count_lead(input logic [39:0] v);
        logic [5:0] n;
        logic run;
        n = '0;
        run = 1'b1;
        for (int i = 38; i >= 0; i--)
        begin
            if (run && (v[i] == v[39]))
                n = n + 6'h01;
            else
                run = 1'b0;
        end
        return n;
    endfunction : count_lead

    assign lead = count_lead(acc);
    assign is_zero = (acc == 40'h00_0000_0000);

    // Exponent: count minus eight, zero for a zero input
    assign exp_val = is_zero ? 16'h0000 : {10'h000, lead} - minsel_alu_pkg::EXP_BIAS;

    // Negated exponent: eight minus count, fixed marker for a zero input
    assign nexp_val = is_zero ? minsel_alu_pkg::NORM_ZERO_VALUE
                              : minsel_alu_pkg::EXP_BIAS - {10'h000, lead};

    // Align on a signed 32-bit value: arithmetic right shift or zero-fill left shift
    always_comb
    begin
        if (lead >= 6'h08)
            mant = acc << (lead - 6'h08);
        else
            mant = 40'($signed(acc) >>> (6'h08 - lead));
    end

endmodule : lead_norm_unit

// >>> logic/dsp_minsel_bitop_normalize_alu.sv
// Fixed-point ALU datapath for min select, compare, bit toggles, complement and normalize
// How it works
// - Difference is second minus first source, 40 bits
// - Narrow mode compares low 32 bits only
// - Wide mode compares 40 bits, tie picks second
// - Decision register shifts right, bit 15 loaded
// - Overflow sets flag; saturate only when enabled
// - Carry is inverse of subtraction borrow
// - Legacy mode forces wide compare for selection
// - Memory word equals immediate sets test flag
// - Accumulator toggle uses six bits, 0 to 39
// - Short register toggle uses low four bits
// - Complement to accumulator inverts 40 zero-extended bits
// - Complement to short register uses 16 bits
// - Memory bit toggle position from four bits
// - Exponent is lead count minus eight
// - Exponent keeps source, zero input gives zero
// - Normalize writes eight minus lead count
// - Normalize aligns source on signed 32 bits
// - Right shift extends sign, left fills zeros
// - Zero normalize source loads 8000h
`timescale 1ns/1ps
module dsp_minsel_bitop_normalize_alu (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    minsel_alu_pkg::state_type st;
    minsel_alu_pkg::state_type next_st;
    logic wr_en;
    logic [40:0] sdiff;
    logic [40:0] udiff;
    logic ovf_wide;
    logic ovf_narrow;
    logic ovf_hit;
    logic cmp_wide;
    logic first_less;
    logic [39:0] dif_out;
    logic [39:0] not_src;
    logic [15:0] short_src;
    logic norm_zero;
    logic [15:0] exp_val;
    logic [15:0] nexp_val;
    logic [39:0] mant;

    // True when the address names a register
    function automatic logic addr_hit(input logic [7:0] a);
        return (a[1:0] == 2'b00) && (a <= minsel_alu_pkg::OFS_STATUS);
    endfunction : addr_hit

    // Flips one bit of a 16-bit word
    function automatic logic [15:0] flip16(input logic [15:0] v, input logic [3:0] pos);
        return v ^ (16'h0001 << pos);
    endfunction : flip16

    // Read data for one register
    function automatic logic [31:0] read_word(input minsel_alu_pkg::state_type s,
                                              input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (a)
            minsel_alu_pkg::OFS_CTRL:
            begin
                r[minsel_alu_pkg::CTRL_OP_LSB +: 4] = s.ctrl.op;
                r[minsel_alu_pkg::CTRL_SAT_BIT] = s.ctrl.sat;
                r[minsel_alu_pkg::CTRL_WIDE_BIT] = s.ctrl.wide;
                r[minsel_alu_pkg::CTRL_LEGACY_BIT] = s.ctrl.legacy;
                r[minsel_alu_pkg::CTRL_DEC_SEL_BIT] = s.ctrl.dec_sel;
                r[minsel_alu_pkg::CTRL_TC_SEL_BIT] = s.ctrl.tc_sel;
                r[minsel_alu_pkg::CTRL_SRC_ACC_BIT] = s.ctrl.src_acc;
                r[minsel_alu_pkg::CTRL_GO_BIT] = s.go;
            end
            minsel_alu_pkg::OFS_SRC_A_LO: r = s.src_a[31:0];
            minsel_alu_pkg::OFS_SRC_A_HI: r[7:0] = s.src_a[39:32];
            minsel_alu_pkg::OFS_SRC_B_LO: r = s.src_b[31:0];
            minsel_alu_pkg::OFS_SRC_B_HI: r[7:0] = s.src_b[39:32];
            minsel_alu_pkg::OFS_WORD: r[15:0] = s.word;
            minsel_alu_pkg::OFS_IMM: r[15:0] = s.imm;
            minsel_alu_pkg::OFS_EXT_LO: r = s.res_ext[31:0];
            minsel_alu_pkg::OFS_EXT_HI: r[7:0] = s.res_ext[39:32];
            minsel_alu_pkg::OFS_DIF_LO: r = s.res_dif[31:0];
            minsel_alu_pkg::OFS_DIF_HI: r[7:0] = s.res_dif[39:32];
            minsel_alu_pkg::OFS_SHORT: r[15:0] = s.res_short;
            minsel_alu_pkg::OFS_DEC_A: r[15:0] = s.dec_a;
            minsel_alu_pkg::OFS_DEC_B: r[15:0] = s.dec_b;
            minsel_alu_pkg::OFS_STATUS:
            begin
                r[minsel_alu_pkg::STAT_OVF_BIT] = s.ovf;
                r[minsel_alu_pkg::STAT_CARRY_BIT] = s.carry;
                r[minsel_alu_pkg::STAT_TC1_BIT] = s.tc1;
                r[minsel_alu_pkg::STAT_TC2_BIT] = s.tc2;
                r[minsel_alu_pkg::STAT_BUSY_BIT] = s.go;
            end
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction : read_word

    // Exponent and mantissa of the first source
    lead_norm_unit lead_norm_unit_i (
        .acc(st.src_a),
        .is_zero(norm_zero),
        .exp_val(exp_val),
        .nexp_val(nexp_val),
        .mant(mant)
    );

    // APB handshake: zero wait states, error on unmapped address
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit(paddr);
    assign prdata = st.rdata;
    assign wr_en = psel && penable && pwrite && addr_hit(paddr);

    // Subtraction second minus first, signed and unsigned views
    assign sdiff = {st.src_b[39], st.src_b} - {st.src_a[39], st.src_a};
    assign udiff = {1'b0, st.src_b} - {1'b0, st.src_a};
    assign ovf_wide = sdiff[40] != sdiff[39];
    assign ovf_narrow = !((&sdiff[40:31]) || !(|sdiff[40:31]));
    assign ovf_hit = st.ctrl.wide ? ovf_wide : ovf_narrow;

    // Saturated or plain difference
    always_comb
    begin
        if (ovf_hit && st.ctrl.sat)
        begin
            if (st.ctrl.wide)
                dif_out = sdiff[40] ? minsel_alu_pkg::SAT_NEG_WIDE
                                    : minsel_alu_pkg::SAT_POS_WIDE;
            else
                dif_out = sdiff[40] ? minsel_alu_pkg::SAT_NEG_NARROW
                                    : minsel_alu_pkg::SAT_POS_NARROW;
        end
        else
            dif_out = sdiff[39:0];
    end

    // Compare width: legacy mode acts as if wide mode were set locally
    assign cmp_wide = st.ctrl.wide || st.ctrl.legacy;
    assign first_less = cmp_wide ? ($signed(st.src_a) < $signed(st.src_b))
                                 : ($signed(st.src_a[31:0]) < $signed(st.src_b[31:0]));

    // Complement operands: short source zero-extended, accumulator source cut to 16 bits
    assign not_src = st.ctrl.src_acc ? ~st.src_a : ~{24'h00_0000, st.word};
    assign short_src = st.ctrl.src_acc ? st.src_a[15:0] : st.word;

    // Next state: read capture, bus writes, then one execute cycle
    always_comb
    begin
        next_st = st;
        if (psel && !penable)
            next_st.rdata = read_word(st, paddr);
        if (wr_en)
        begin
            case (paddr)
                minsel_alu_pkg::OFS_CTRL:
                begin
                    next_st.ctrl.op = pwdata[minsel_alu_pkg::CTRL_OP_LSB +: 4];
                    next_st.ctrl.sat = pwdata[minsel_alu_pkg::CTRL_SAT_BIT];
                    next_st.ctrl.wide = pwdata[minsel_alu_pkg::CTRL_WIDE_BIT];
                    next_st.ctrl.legacy = pwdata[minsel_alu_pkg::CTRL_LEGACY_BIT];
                    next_st.ctrl.dec_sel = pwdata[minsel_alu_pkg::CTRL_DEC_SEL_BIT];
                    next_st.ctrl.tc_sel = pwdata[minsel_alu_pkg::CTRL_TC_SEL_BIT];
                    next_st.ctrl.src_acc = pwdata[minsel_alu_pkg::CTRL_SRC_ACC_BIT];
                    next_st.go = pwdata[minsel_alu_pkg::CTRL_GO_BIT];
                end
                minsel_alu_pkg::OFS_SRC_A_LO: next_st.src_a[31:0] = pwdata;
                minsel_alu_pkg::OFS_SRC_A_HI: next_st.src_a[39:32] = pwdata[7:0];
                minsel_alu_pkg::OFS_SRC_B_LO: next_st.src_b[31:0] = pwdata;
                minsel_alu_pkg::OFS_SRC_B_HI: next_st.src_b[39:32] = pwdata[7:0];
                minsel_alu_pkg::OFS_WORD: next_st.word = pwdata[15:0];
                minsel_alu_pkg::OFS_IMM: next_st.imm = pwdata[15:0];
                minsel_alu_pkg::OFS_DEC_A: next_st.dec_a = pwdata[15:0];
                minsel_alu_pkg::OFS_DEC_B: next_st.dec_b = pwdata[15:0];
                minsel_alu_pkg::OFS_STATUS:
                    if (pwdata[minsel_alu_pkg::STAT_OVF_BIT])
                        next_st.ovf = 1'b0;
                default: next_st.go = st.go;
            endcase
        end
        if (st.go)
        begin
            next_st.go = 1'b0;
            case (minsel_alu_pkg::op_type'(st.ctrl.op))
                minsel_alu_pkg::OP_MINSEL:
                begin
                    next_st.res_dif = dif_out;
                    next_st.res_ext = first_less ? st.src_a : st.src_b;
                    next_st.carry = !udiff[40];
                    if (ovf_hit)
                        next_st.ovf = 1'b1;
                    if (st.ctrl.dec_sel)
                        next_st.dec_b = {!first_less, st.dec_b[15:1]};
                    else
                        next_st.dec_a = {!first_less, st.dec_a[15:1]};
                end
                minsel_alu_pkg::OP_CMP_MEM:
                begin
                    if (st.ctrl.tc_sel)
                        next_st.tc2 = (st.word == st.imm);
                    else
                        next_st.tc1 = (st.word == st.imm);
                end
                minsel_alu_pkg::OP_TGL_ACC:
                begin
                    next_st.res_ext = st.src_a;
                    if (st.imm[5:0] <= minsel_alu_pkg::ACC_TOP_BIT)
                        next_st.res_ext[st.imm[5:0]] = !st.src_a[st.imm[5:0]];
                end
                minsel_alu_pkg::OP_TGL_SHORT:
                    next_st.res_short = flip16(st.word, st.imm[3:0]);
                minsel_alu_pkg::OP_NOT_ACC:
                    next_st.res_ext = not_src;
                minsel_alu_pkg::OP_NOT_SHORT:
                    next_st.res_short = ~short_src;
                minsel_alu_pkg::OP_TGL_MEM:
                    next_st.res_short = flip16(st.word, st.imm[3:0]);
                minsel_alu_pkg::OP_EXP:
                    next_st.res_short = exp_val;
                minsel_alu_pkg::OP_NORM:
                begin
                    next_st.res_short = nexp_val;
                    next_st.res_ext = mant;
                end
                default: next_st.res_short = st.res_short;
            endcase
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= minsel_alu_pkg::STATE_RESET;
        else
            st <= next_st;
    end

    // Checks on the executed operations
    AST_DIFF_VALUE: assert property (@(posedge pclk) disable iff (!presetn)
        (st.go && st.ctrl.op == minsel_alu_pkg::OP_MINSEL && !st.ctrl.sat)
        |=> (st.res_dif == $past(st.src_b) - $past(st.src_a)))
        else $error("difference result wrong");

    AST_NARROW_PICK: assert property (@(posedge pclk) disable iff (!presetn)
        (st.go && st.ctrl.op == minsel_alu_pkg::OP_MINSEL && !st.ctrl.wide && !st.ctrl.legacy)
        |=> (st.res_ext == (($signed($past(st.src_a[31:0])) < $signed($past(st.src_b[31:0])))
                            ? $past(st.src_a) : $past(st.src_b))))
        else $error("narrow minimum pick wrong");

    AST_WIDE_PICK: assert property (@(posedge pclk) disable iff (!presetn)
        (st.go && st.ctrl.op == minsel_alu_pkg::OP_MINSEL && st.ctrl.wide)
        |=> (st.res_ext == (($signed($past(st.src_a)) < $signed($past(st.src_b)))
                            ? $past(st.src_a) : $past(st.src_b))))
        else $error("wide minimum pick wrong");

    AST_DECISION: assert property (@(posedge pclk) disable iff (!presetn)
        (st.go && st.ctrl.op == minsel_alu_pkg::OP_MINSEL && !st.ctrl.dec_sel)
        |=> (st.dec_a[14:0] == $past(st.dec_a[15:1]))
            && (st.dec_a[15] == ((st.res_ext != $past(st.src_a))
                                 || ($past(st.src_a) == $past(st.src_b)))))
        else $error("decision register not shifted");

    AST_SATURATE: assert property (@(posedge pclk) disable iff (!presetn)
        (st.go && st.ctrl.op == minsel_alu_pkg::OP_MINSEL && st.ctrl.sat && st.ctrl.wide
         && ovf_wide)
        |=> st.ovf && (st.res_dif == minsel_alu_pkg::SAT_NEG_WIDE
                       || st.res_dif == minsel_alu_pkg::SAT_POS_WIDE))
        else $error("overflow not saturated or flagged");

    AST_CARRY: assert property (@(posedge pclk) disable iff (!presetn)
        (st.go && st.ctrl.op == minsel_alu_pkg::OP_MINSEL)
        |=> (st.carry == ($past(st.src_b) >= $past(st.src_a))))
        else $error("carry not inverse of borrow");

    AST_LEGACY: assert property (@(posedge pclk) disable iff (!presetn)
        (st.go && st.ctrl.op == minsel_alu_pkg::OP_MINSEL && st.ctrl.legacy)
        |=> (st.res_ext == (($signed($past(st.src_a)) < $signed($past(st.src_b)))
                            ? $past(st.src_a) : $past(st.src_b))))
        else $error("legacy mode did not compare wide");

    AST_COMPARE: assert property (@(posedge pclk) disable iff (!presetn)
        (st.go && st.ctrl.op == minsel_alu_pkg::OP_CMP_MEM && !st.ctrl.tc_sel)
        |=> (st.tc1 == ($past(st.word) == $past(st.imm))))
        else $error("test flag wrong after compare");

    AST_TOGGLE_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
        (st.go && st.ctrl.op == minsel_alu_pkg::OP_TGL_ACC && st.imm[5:0] > 6'h27)
        |=> (st.res_ext == $past(st.src_a)))
        else $error("out-of-range toggle changed register");

    AST_EXP_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        (st.go && st.ctrl.op == minsel_alu_pkg::OP_EXP && st.src_a == 40'h00_0000_0000)
        |=> (st.res_short == 16'h0000) && $stable(st.src_a))
        else $error("exponent of zero not zero");

    AST_NORM_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        (st.go && st.ctrl.op == minsel_alu_pkg::OP_NORM && st.src_a == 40'h00_0000_0000)
        |=> (st.res_short == 16'h8000))
        else $error("normalize of zero wrong marker");

    AST_ONE_CYCLE: assert property (@(posedge pclk) disable iff (!presetn)
        st.go |=> !st.go)
        else $error("operation took more than one cycle");

    AST_COMPARE_B: assert property (@(posedge pclk) disable iff (!presetn)
        (st.go && st.ctrl.op == minsel_alu_pkg::OP_CMP_MEM && st.ctrl.tc_sel)
        |=> (st.tc2 == ($past(st.word) == $past(st.imm))) && $stable(st.tc1))
        else $error("second test flag wrong after compare");

    AST_TOGGLE_BIT: assert property (@(posedge pclk) disable iff (!presetn)
        (st.go && st.ctrl.op == minsel_alu_pkg::OP_TGL_ACC && st.imm[5:0] <= 6'h27)
        |=> ((st.res_ext ^ $past(st.src_a)) == (40'h00_0000_0001 << $past(st.imm[5:0]))))
        else $error("accumulator bit toggle wrong");

    AST_SHORT_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
        (st.go && (st.ctrl.op == minsel_alu_pkg::OP_TGL_SHORT
                   || st.ctrl.op == minsel_alu_pkg::OP_TGL_MEM))
        |=> ((st.res_short ^ $past(st.word)) == (16'h0001 << $past(st.imm[3:0]))))
        else $error("short or memory bit toggle wrong");

    AST_NOT_WIDE: assert property (@(posedge pclk) disable iff (!presetn)
        (st.go && st.ctrl.op == minsel_alu_pkg::OP_NOT_ACC)
        |=> ((st.res_ext ^ ($past(st.ctrl.src_acc) ? $past(st.src_a)
                            : {24'h00_0000, $past(st.word)})) == 40'hFF_FFFF_FFFF))
        else $error("accumulator complement wrong");

    AST_NOT_SHORT: assert property (@(posedge pclk) disable iff (!presetn)
        (st.go && st.ctrl.op == minsel_alu_pkg::OP_NOT_SHORT)
        |=> ((st.res_short ^ ($past(st.ctrl.src_acc) ? $past(st.src_a[15:0])
                              : $past(st.word))) == 16'hFFFF))
        else $error("short complement wrong");

    AST_NORM_ALIGN: assert property (@(posedge pclk) disable iff (!presetn)
        (st.go && st.ctrl.op == minsel_alu_pkg::OP_NORM && st.src_a != 40'h00_0000_0000)
        |=> (st.res_ext[39:31] == {9{st.res_ext[31]}}) && (st.res_ext[30] != st.res_ext[31]))
        else $error("mantissa not aligned on 32 bits");

endmodule : dsp_minsel_bitop_normalize_alu

// >>> dv/apb_host_model.sv
// APB requester standing in for the decoder and operand fetch side
`timescale 1ns/1ps
module apb_host_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Idle bus at time zero
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // One transfer: setup, then access held until pready at a rising edge
    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
              output logic [31:0] q, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wr ? d : ~pwdata; // Reads carry changing data, never a stale copy
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : apb_host_model

// >>> dv/test_dsp_minsel_bitop_normalize_alu.sv
// Self-checking bench for the min select, bit operation and normalize datapath
`timescale 1ns/1ps
module test_dsp_minsel_bitop_normalize_alu;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;

    dsp_minsel_bitop_normalize_alu dsp_minsel_bitop_normalize_alu_i (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    apb_host_model apb_host_model_i (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    // Compare and count
    task chk(input logic [39:0] seen, input logic [39:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb_host_model_i.xfer(1'b1, a, d, q, err);
    endtask : wr
    task rd(input logic [7:0] a);
        apb_host_model_i.xfer(1'b0, a, 32'h0, q, err);
    endtask : rd
    // 40-bit values travel as low word then high byte
    task put(input logic [7:0] a, input logic [39:0] v);
        wr(a, v[31:0]);
        wr(a + 8'h04, {24'h0, v[39:32]});
    endtask : put
    task res(input logic [7:0] a, input logic [39:0] exp);
        logic [39:0] v;
        rd(a);
        v = {8'h00, q};
        if (a != 8'h2C)
        begin
            rd(a + 8'h04);
            v[39:32] = q[7:0];
        end
        chk(v, exp);
    endtask : res
    // Start one operation; f holds control bits 9 down to 4
    task go(input logic [3:0] op, input logic [5:0] f);
        wr(8'h00, {1'b1, 21'h0, f, op});
    endtask : go

    // Reset values, unmapped address, read-only result
    task t_bus;
        rd(8'h38);
        chk(q, 32'h0);
        rd(8'h3C);
        chk({err, q}, {1'b1, 32'h0});
        wr(8'h1C, 32'hFFFF_FFFF);
        rd(8'h1C);
        chk(q, 32'h0);
    endtask : t_bus

    // Minimum select in narrow, wide and legacy modes
    task t_minsel;
        wr(8'h34, 32'h0002);
        put(8'h04, 40'h00_0000_0003);
        put(8'h0C, 40'h00_0000_0005);
        go(4'h0, 6'b001000);
        res(8'h24, 40'h00_0000_0002);
        res(8'h1C, 40'h00_0000_0003);
        rd(8'h34);
        chk(q, 32'h0001);
        rd(8'h38);
        chk(q[1:0], 2'b10);
        wr(8'h30, 32'h8000);
        put(8'h04, 40'h01_0000_0000);
        put(8'h0C, 40'h00_0000_0001);
        go(4'h0, 6'b000001);
        res(8'h24, 40'hFF_8000_0000);
        res(8'h1C, 40'h01_0000_0000);
        rd(8'h38);
        chk(q[1:0], 2'b01);
        wr(8'h38, 32'h1);
        go(4'h0, 6'b000011);
        res(8'h24, 40'hFF_0000_0001);
        res(8'h1C, 40'h00_0000_0001);
        rd(8'h38);
        chk(q[0], 1'b0);
        go(4'h0, 6'b000100); // Wide mode kept clear under legacy mode
        res(8'h1C, 40'h00_0000_0001);
        res(8'h24, 40'hFF_0000_0001);
        rd(8'h30);
        chk(q, 32'hD000);
        put(8'h04, 40'h00_0000_0001);
        go(4'h0, 6'b000010);
        rd(8'h30);
        chk(q, 32'hE800);
        wr(8'h38, 32'h1);
        put(8'h04, 40'h80_0000_0000);
        go(4'h0, 6'b000011);
        res(8'h24, 40'h7F_FFFF_FFFF);
        res(8'h1C, 40'h80_0000_0000);
        rd(8'h38);
        chk(q[1:0], 2'b01);
    endtask : t_minsel

    // Memory word against immediate, both test flags
    task t_cmp;
        wr(8'h14, 32'h0400);
        wr(8'h18, 32'h0400);
        go(4'h1, 6'h00);
        go(4'h1, 6'h10);
        rd(8'h38);
        chk(q[3:2], 2'b11);
        wr(8'h18, 32'hFC00);
        go(4'h1, 6'h00);
        rd(8'h38);
        chk(q[3:2], 2'b10);
    endtask : t_cmp

    // Single-bit toggles of accumulator, short register and memory word
    task t_toggle;
        put(8'h04, 40'h10_2400_2222);
        wr(8'h18, 32'h0027);
        go(4'h2, 6'h00);
        res(8'h1C, 40'h90_2400_2222);
        wr(8'h18, 32'h0028);
        go(4'h2, 6'h00);
        res(8'h1C, 40'h10_2400_2222);
        wr(8'h18, 32'h0041);
        go(4'h2, 6'h00);
        res(8'h1C, 40'h10_2400_2220);
        wr(8'h14, 32'hE000);
        wr(8'h18, 32'h001C);
        go(4'h3, 6'h00);
        res(8'h2C, 40'hF000);
        wr(8'h14, 32'h8001);
        wr(8'h18, 32'h003F);
        go(4'h6, 6'h00);
        res(8'h2C, 40'h0001);
    endtask : t_toggle

    // Complement into accumulator and into short register
    task t_not;
        put(8'h04, 40'h7E_2355_4FC0);
        wr(8'h14, 32'h1234);
        go(4'h4, 6'h20);
        res(8'h1C, 40'h81_DCAA_B03F);
        go(4'h4, 6'h00);
        res(8'h1C, 40'hFF_FFFF_EDCB);
        go(4'h5, 6'h20);
        res(8'h2C, 40'hB03F);
        go(4'h5, 6'h00);
        res(8'h2C, 40'hEDCB);
    endtask : t_not

    // Exponent and normalize over a table of sources, zero last
    task t_norm;
        logic [39:0] s [6] = '{40'hFF_FFFF_FFCB, 40'h21_0A0A_0A0A, 40'h00_E804_0000,
            40'h00_0000_0001, 40'h80_0000_0000, 40'h0};
        logic [15:0] e [6] = '{16'h0019, 16'hFFF9, 16'hFFFF, 16'h001E, 16'hFFF8, 16'h0};
        logic [15:0] n [6] = '{16'hFFE7, 16'h0007, 16'h0001, 16'hFFE2, 16'h0008, 16'h8000};
        logic [39:0] m [5] = '{40'hFF_9600_0000, 40'h00_4214_1414, 40'h00_7402_0000,
            40'h00_4000_0000, 40'hFF_8000_0000};
        for (int i = 0; i < 6; i++)
        begin
            put(8'h04, s[i]);
            go(4'h7, 6'h00);
            res(8'h2C, e[i]);
            res(8'h04, s[i]);
            go(4'h8, 6'h00);
            res(8'h2C, n[i]);
            if (i < 5)
                res(8'h1C, m[i]);
        end
    endtask : t_norm

    // Counts, verdict and end of run
    task wrap_up;
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    // Clock
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Reset then scenarios
    initial
    begin
        presetn = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_bus;
        t_minsel;
        t_cmp;
        t_toggle;
        t_not;
        t_norm;
        wrap_up;
    end

    // Hang guard
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_fail++;
            wrap_up;
        end
    end
endmodule : test_dsp_minsel_bitop_normalize_alu
